// *** rtl/ses_consts.svh ***
`ifndef SES_CONSTS_SVH
`define SES_CONSTS_SVH
// Reset values and sequencing counts
`define SES_PIN_RST        3'h6
`define SES_CNT_RST        4'h0
`define SES_SWITCH_CYCLES  4'h4
`define SES_RTC_DIV        16'h0000
`endif

// *** rtl/ses_pkg.sv ***
package ses_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    SES_HOLD   = 2'b00,
    SES_SWITCH = 2'b01,
    SES_FROZEN = 2'b10,
    SES_RUN    = 2'b11
  } ses_state_type;

  // RAM interface status bundle
  typedef struct packed {
    logic on_core;
    logic frozen;
    logic access;
  } ses_ram_type;
endpackage

// *** rtl/ses_standby_exit_sequencer.sv ***
// Contract
// - Standby exit is a normal power-on; retained RAM stays powered from standby supply.
// - Device holds itself in reset from low-voltage detector until core supply is up.
// - On internal reset release RAM moves to core supply while interface stays frozen.
// - RAM access stays blocked after reset until software sets RAM enable bit.
// - RTC counts through standby with 32 kHz reference; main reference stops when off.
// - Clearing RAM enable freezes the retained RAM interface at once.
// - Core supply below standby reference keeps RAM frozen regardless of enable bit.
`timescale 1ns/1ns
`default_nettype none
`include "ses_consts.svh"

module ses_standby_exit_sequencer #(
  parameter logic [3:0] SWITCH_CYCLES = `SES_SWITCH_CYCLES
) (
  input  wire logic I_CLK,
  input  wire logic I_RST_N,
  input  wire logic I_EXTERNAL_RESET_PIN_N,
  input  wire logic I_LOW_VOLTAGE_DETECTOR,
  input  wire logic I_CORE_SUPPLY_LOW,
  input  wire logic I_RETAINED_RAM_ENABLE,
  input  wire logic I_RTC_REF_LOWPOWER,
  input  wire logic I_RTC_TICK,
  output var  logic O_INTERNAL_RESET_N,
  output var  logic O_RAM_ON_CORE_SUPPLY,
  output var  logic O_RAM_FROZEN,
  output var  logic O_RAM_ACCESS_EN,
  output var  logic O_RTC_COUNT_EN
);

  // Refuse a zero settle count, which would end the switch after one cycle, as a count of one does
  generate
    if (SWITCH_CYCLES == 4'h0) begin : g_bad_switch
      $error("SWITCH_CYCLES must be at least one");
    end
  endgenerate

  // Pin-side levels: bit 0 reset pin, bit 1 detector, bit 2 core low
  localparam int unsigned          PIN_COUNT = 3;
  localparam logic [PIN_COUNT-1:0] PIN_RST   = `SES_PIN_RST;  // Pin low, detector on, core low

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_stable;
  logic                 rst_pin_stable;
  logic                 det_stable;
  logic                 low_stable;
  logic                 rst_pin_ok;
  logic                 det_ok;
  logic                 low_ok;

  assign pin_raw = {I_CORE_SUPPLY_LOW, I_LOW_VOLTAGE_DETECTOR, I_EXTERNAL_RESET_PIN_N};

  // Three stages per level; one-cycle glitches never reach the level
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_sync
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       level;
    logic       next_level;

    // Shift the pin in; adopt it once stages two and three agree
    always_comb begin
      next_stage = {stage[1:0], pin_raw[g]};
      next_level = level;
      if (stage[1] == stage[2]) begin
        next_level = stage[2];
      end
    end

    // Synchroniser registers, reset to the safe side of each level
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        stage <= {3{PIN_RST[g]}};
        level <= PIN_RST[g];
      end else begin
        stage <= next_stage;
        level <= next_level;
      end
    end

    assign pin_stable[g] = level;
  end

  // Reset holds while pin low or detector active
  assign rst_pin_stable = pin_stable[0];
  assign det_stable     = pin_stable[1];
  assign low_stable     = pin_stable[2];
  assign rst_pin_ok     = rst_pin_stable;
  assign det_ok         = !det_stable;
  assign low_ok         = !low_stable;

  // Sequencer next-state logic
  ses_pkg::ses_state_type state;
  ses_pkg::ses_state_type next_state;
  logic [3:0]             cnt;
  logic [3:0]             next_cnt;
  ses_pkg::ses_ram_type   ram;
  ses_pkg::ses_ram_type   next_ram;
  logic                   int_rst_n;
  logic                   next_int_rst_n;

  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_int_rst_n = int_rst_n;
    next_ram       = ram;
    case (state)
      ses_pkg::SES_HOLD: begin
        next_int_rst_n = 1'b0;
        next_ram       = '{on_core: 1'b0, frozen: 1'b1, access: 1'b0};
        next_cnt       = `SES_CNT_RST;
        if (rst_pin_ok && det_ok) begin
          next_state = ses_pkg::SES_SWITCH;
        end
      end
      ses_pkg::SES_SWITCH: begin
        next_int_rst_n = 1'b1;
        next_ram.on_core = 1'b1;
        next_ram.frozen  = 1'b1;
        next_cnt = cnt + 4'h1;
        if (cnt + 4'h1 >= SWITCH_CYCLES) begin
          next_state = ses_pkg::SES_FROZEN;
        end
      end
      ses_pkg::SES_FROZEN: begin
        next_ram.frozen = 1'b1;
        next_ram.access = 1'b0;
        if (I_RETAINED_RAM_ENABLE && low_ok) begin
          next_state = ses_pkg::SES_RUN;
          next_ram.frozen = 1'b0;
          next_ram.access = 1'b1;
        end
      end
      ses_pkg::SES_RUN: begin
        if (!I_RETAINED_RAM_ENABLE || !low_ok) begin
          next_state = ses_pkg::SES_FROZEN;
          next_ram.frozen = 1'b1;
          next_ram.access = 1'b0;
        end
      end
      default: begin
        next_state = ses_pkg::SES_HOLD;
      end
    endcase
    if (!(rst_pin_ok && det_ok)) begin
      next_state     = ses_pkg::SES_HOLD;
      next_int_rst_n = 1'b0;
      next_ram       = '{on_core: 1'b0, frozen: 1'b1, access: 1'b0};
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state     <= ses_pkg::SES_HOLD;
      cnt       <= `SES_CNT_RST;
      int_rst_n <= 1'b0;
      ram       <= '{on_core: 1'b0, frozen: 1'b1, access: 1'b0};
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      int_rst_n <= next_int_rst_n;
      ram       <= next_ram;
    end
  end

  // RTC count enable by reference choice
  logic rtc_en;
  logic next_rtc_en;

  always_comb begin
    next_rtc_en = I_RTC_TICK && (I_RTC_REF_LOWPOWER || int_rst_n);
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rtc_en <= 1'b0;
    end else begin
      rtc_en <= next_rtc_en;
    end
  end

  // Outputs straight from flops
  assign O_INTERNAL_RESET_N   = int_rst_n;
  assign O_RAM_ON_CORE_SUPPLY = ram.on_core;
  assign O_RAM_FROZEN         = ram.frozen;
  assign O_RAM_ACCESS_EN      = ram.access;
  assign O_RTC_COUNT_EN       = rtc_en;

  // Checks
  chk_frozen_in_reset: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !int_rst_n |-> ram.frozen && !ram.access)
    else $error("RAM not frozen during reset");
  chk_pin_holds_reset: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !rst_pin_stable |=> !int_rst_n)
    else $error("reset released with pin low");
  chk_det_holds_reset: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    det_stable |=> !int_rst_n)
    else $error("reset released with detector active");
  chk_switch_on_release: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(int_rst_n) |-> ram.on_core && ram.frozen)
    else $error("supply not switched on release");
  chk_supply_follows_reset: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ram.on_core == int_rst_n)
    else $error("RAM supply does not follow internal reset");
  chk_enable_gates_access: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(ram.access) |-> $past(I_RETAINED_RAM_ENABLE))
    else $error("access without enable");
  chk_access_unfreezes: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ram.access |-> !ram.frozen)
    else $error("access granted while frozen");
  chk_rtc_main_stops: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !I_RTC_REF_LOWPOWER && !int_rst_n |=> !rtc_en)
    else $error("rtc counts on main ref in reset");
  chk_lowpower_counts: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_RTC_TICK && I_RTC_REF_LOWPOWER |=> rtc_en)
    else $error("rtc tick lost on low-power ref");
  chk_clear_freezes: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ram.access && !I_RETAINED_RAM_ENABLE |=> ram.frozen && !ram.access)
    else $error("clear did not freeze");
  chk_low_core_frozen: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    low_stable |=> !ram.access)
    else $error("access while core low");
  chk_switch_before_en: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(int_rst_n) |-> !ram.access [*4])
    else $error("enable before switch done");

endmodule
`default_nettype wire

// *** tb/ses_supply_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module ses_supply_model (
  input  wire logic i_clk,
  input  wire logic i_power_on,
  output wire logic o_pin_n,
  output wire logic o_det,
  output wire logic o_core_low
);
  logic [3:0] ramp = 4'h0;
  // Supply ramp counter, cleared at once on power loss
  always @(posedge i_clk) begin
    ramp <= !i_power_on ? 4'h0 : (ramp == 4'hF) ? ramp : ramp + 4'h1;
  end
  // Detector, core level and pin released in that order
  assign o_det = !(i_power_on && ramp > 4'h2);
  assign o_core_low = !(i_power_on && ramp > 4'h4);
  assign o_pin_n = i_power_on && ramp > 4'h8;
endmodule
`default_nettype wire

// *** tb/standby_exit_sequencer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module standby_exit_sequencer_tb;
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, dip = 1'b0;
  logic en = 1'b0, ref_lp = 1'b0, tick = 1'b0;
  logic [31:0] lfsr = 32'hABD5CEDE;
  wire pin_n, det, core_low, irst_n, on_core, frozen, acc, cnt;
  int failures = 0;
  int checked = 0;
  ses_supply_model sup (.i_clk(clk), .i_power_on(pwr), .o_pin_n(pin_n), .o_det(det),
    .o_core_low(core_low));
  ses_standby_exit_sequencer #(.SWITCH_CYCLES(4'h4)) dut (.I_CLK(clk), .I_RST_N(rst_n),
    .I_EXTERNAL_RESET_PIN_N(pin_n), .I_LOW_VOLTAGE_DETECTOR(det),
    .I_CORE_SUPPLY_LOW(core_low | dip), .I_RETAINED_RAM_ENABLE(en),
    .I_RTC_REF_LOWPOWER(ref_lp), .I_RTC_TICK(tick), .O_INTERNAL_RESET_N(irst_n),
    .O_RAM_ON_CORE_SUPPLY(on_core), .O_RAM_FROZEN(frozen), .O_RAM_ACCESS_EN(acc),
    .O_RTC_COUNT_EN(cnt));
  // Random source and expected count pulse
  function automatic logic [31:0] next_lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic exp_count(input logic t, input logic r, input logic on);
    return t & (r | on);
  endfunction
  // Bit compare
  task automatic chk(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Bounded wait on internal reset (sel 0) or access (sel 1)
  task automatic wait_for(input bit sel, input logic want);
    int n;
    n = 0;
    @(negedge clk);
    while (((sel ? acc : irst_n) !== want) && n < 40) begin
      @(negedge clk);
      n++;
    end
    if ((sel ? acc : irst_n) !== want) begin
      failures++;
      $display("ERROR wait expected %b seen timeout", want);
    end
  endtask
  // Random ticks and references, one pulse per two cycles
  task automatic rtc_phase(input logic on);
    logic t, r;
    repeat (40) begin
      @(posedge clk);
      lfsr = next_lfsr(lfsr);
      t = lfsr[0];
      r = lfsr[5];
      tick <= t;
      ref_lp <= r;
      @(posedge clk);
      tick <= 1'b0;
      @(negedge clk);
      chk("count", exp_count(t, r, on), cnt);
    end
    $display("test rtc done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Clock
  initial begin
    forever #20 clk = ~clk;
  end
  // Watchdog
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    en <= 1'b1;
    pwr <= 1'b1;
    wait_for(1'b0, 1'b1);
    chk("on_core", 1'b1, on_core);
    chk("frozen", 1'b1, frozen);
    chk("access", 1'b0, acc);
    wait_for(1'b1, 1'b1);
    chk("frozen", 1'b0, frozen);
    @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("frozen", 1'b1, frozen);
    chk("access", 1'b0, acc);
    // Enable still clear: access must stay blocked
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("access", 1'b0, acc);
    @(posedge clk);
    en <= 1'b1;
    wait_for(1'b1, 1'b1);
    @(posedge clk);
    dip <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("access", 1'b0, acc);
    chk("frozen", 1'b1, frozen);
    @(posedge clk);
    dip <= 1'b0;
    wait_for(1'b1, 1'b1);
    $display("test exit done");
    // Reset pulse in mid-run, then a fresh release
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("reset irst_n", 1'b0, irst_n);
    chk("reset on_core", 1'b0, on_core);
    chk("reset frozen", 1'b1, frozen);
    chk("reset access", 1'b0, acc);
    chk("reset count", 1'b0, cnt);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_for(1'b1, 1'b1);
    chk("on_core", 1'b1, on_core);
    $display("test reset done");
    rtc_phase(1'b1);
    @(posedge clk);
    pwr <= 1'b0;
    wait_for(1'b0, 1'b0);
    chk("on_core", 1'b0, on_core);
    chk("frozen", 1'b1, frozen);
    chk("access", 1'b0, acc);
    $display("test power off done");
    rtc_phase(1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
